// File: rtl/acp_pkg.sv
// shared constants and types of the ascii command parser
package acp_pkg;

  localparam int CLK_MHZ        = 200;
  localparam int TURN_STEP_MS   = 10;
  localparam int TURN_STEP_CYC  = TURN_STEP_MS * 1000 * CLK_MHZ;
  localparam int LOAD_HOLD_MS   = 3000;
  localparam int LOAD_HOLD_CYC  = LOAD_HOLD_MS * 1000 * CLK_MHZ;

  localparam logic [13:0] VALUE_MAX     = 14'h270f;
  localparam logic [13:0] SEL_MAX       = 14'h000f;
  localparam logic [13:0] ADDR_MAX      = 14'h0063;
  localparam logic [6:0]  ADDR_BCAST    = 7'h00;
  localparam logic [8:0]  BLOCK_LAST    = 9'h1ff;
  localparam logic [2:0]  NAME_LEN      = 3'h4;
  localparam logic [13:0] PROG_FIRST    = 14'h0001;
  localparam logic [13:0] PROG_LAST     = 14'h0006;
  localparam logic [2:0]  BAUD_MIN      = 3'h1;
  localparam logic [2:0]  BAUD_MAX      = 3'h5;
  localparam logic [2:0]  BAUD_RESET    = 3'h1;
  localparam logic [5:0]  TURN_MIN      = 6'h01;
  localparam logic [5:0]  TURN_MAX      = 6'h32;
  localparam logic [3:0]  REPLY_VAL_END = 4'h9;
  localparam logic [3:0]  REPLY_YN_END  = 4'h1;

  localparam logic [7:0] CHR_CR    = 8'h0d;
  localparam logic [7:0] CHR_COMMA = 8'h2c;
  localparam logic [7:0] CHR_SPACE = 8'h20;
  localparam logic [7:0] CHR_BANG  = 8'h21;
  localparam logic [7:0] CHR_QUERY = 8'h3f;
  localparam logic [7:0] CHR_EQUAL = 8'h3d;
  localparam logic [7:0] CHR_0     = 8'h30;
  localparam logic [7:0] CHR_9     = 8'h39;
  localparam logic [7:0] CHR_A     = 8'h41;
  localparam logic [7:0] CHR_Z     = 8'h5a;
  localparam logic [7:0] CHR_Y     = 8'h59;
  localparam logic [7:0] CHR_N     = 8'h4e;

  localparam logic [15:0] CMD_SET_TARGET     = 16'h5350;
  localparam logic [15:0] CMD_WRITE_PARAM    = 16'h5356;
  localparam logic [15:0] CMD_LABEL_PROGRAM  = 16'h4e50;
  localparam logic [15:0] CMD_SELECT_PROGRAM = 16'h4350;
  localparam logic [15:0] CMD_READ_PARAM     = 16'h5256;

  typedef enum logic [7:0] {
    ST_IDLE  = 8'h01,
    ST_CMD2  = 8'h02,
    ST_ADDR  = 8'h04,
    ST_FIELD = 8'h08,
    ST_NAME  = 8'h10,
    ST_SKIP  = 8'h20,
    ST_EXEC  = 8'h40,
    ST_WAIT  = 8'h80
  } acp_state_t;

  typedef enum logic [3:0] {
    CFG_IDLE  = 4'h1,
    CFG_ARMED = 4'h2,
    CFG_HOLD  = 4'h4,
    CFG_STEP  = 4'h8
  } acp_cfg_t;

  typedef enum logic [2:0] {
    RS_IDLE = 3'h1,
    RS_WAIT = 3'h2,
    RS_SEND = 3'h4
  } acp_rstate_t;

  typedef enum logic [1:0] {
    RPL_YES   = 2'h0,
    RPL_NO    = 2'h1,
    RPL_VALUE = 2'h2
  } acp_reply_t;

endpackage : acp_pkg

// File: rtl/acp_reply.sv
// reply sender: turnaround wait, then Y, N or value,point characters ending in CR
module acp_reply #(
  parameter int STEP_CYC = acp_pkg::TURN_STEP_CYC
) (
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              start,
  input  wire acp_pkg::acp_reply_t kind,
  input  wire logic [13:0]       value,
  input  wire logic [2:0]        dp,
  input  wire logic [5:0]        turn,
  input  wire logic              tx_ready,
  output logic      [7:0]        tx_data,
  output logic                   tx_valid,
  output logic                   busy
);

  typedef struct packed {
    acp_pkg::acp_rstate_t st;
    acp_pkg::acp_reply_t  kind;
    logic [13:0]          val;
    logic [2:0]           dp;
    logic [5:0]           units;
    logic [31:0]          cyc;
    logic [3:0]           idx;
    logic [7:0]           data;
  } acp_rpl_t;

  acp_rpl_t q, n;

  function automatic logic [7:0] dec_char(input logic [13:0] v, input logic [1:0] pos);
    logic [13:0] s;
    case (pos)
      2'd3:    s = v / 14'd1000;
      2'd2:    s = v / 14'd100;
      2'd1:    s = v / 14'd10;
      default: s = v;
    endcase
    s = s % 14'd10;
    return acp_pkg::CHR_0 + s[7:0];
  endfunction : dec_char

  function automatic logic [7:0] char_at(input acp_rpl_t r, input logic [3:0] i);
    logic [7:0] c;
    c = acp_pkg::CHR_CR;
    if (r.kind == acp_pkg::RPL_VALUE) begin
      // both numbers always go out as four digits with leading zeros
      if (i < 4'd4)
        c = dec_char(r.val, 2'(3 - i));
      else if (i == 4'd4)
        c = acp_pkg::CHR_COMMA;
      else if (i < 4'd9)
        c = dec_char({11'h000, r.dp}, 2'(8 - i));
    end else if (i == 4'd0) begin
      c = (r.kind == acp_pkg::RPL_YES) ? acp_pkg::CHR_Y : acp_pkg::CHR_N;
    end
    return c;
  endfunction : char_at

  logic [3:0] last;

  always_comb begin
    n    = q;
    // every reply stops at its CR, no linefeed follows
    last = (q.kind == acp_pkg::RPL_VALUE) ? acp_pkg::REPLY_VAL_END : acp_pkg::REPLY_YN_END;
    unique case (q.st)
      acp_pkg::RS_IDLE: begin
        if (start) begin
          n.st   = acp_pkg::RS_WAIT;
          n.kind = kind;
          n.val  = value;
          n.dp   = dp;
          n.cyc  = 32'h0;
          // settings outside 1..50 are clamped rather than trusted
          if (turn < acp_pkg::TURN_MIN)
            n.units = acp_pkg::TURN_MIN;
          else if (turn > acp_pkg::TURN_MAX)
            n.units = acp_pkg::TURN_MAX;
          else
            n.units = turn;
        end
      end
      acp_pkg::RS_WAIT: begin
        // turnaround delay of units times 10 ms before the first character
        n.cyc = q.cyc + 32'h1;
        if (q.cyc == 32'(STEP_CYC - 1)) begin
          n.cyc   = 32'h0;
          n.units = q.units - 6'h01;
          if (q.units == 6'h01) begin
            n.st   = acp_pkg::RS_SEND;
            n.idx  = 4'h0;
            n.data = char_at(q, 4'h0);
          end
        end
      end
      acp_pkg::RS_SEND: begin
        if (tx_ready) begin
          if (q.idx == last) begin
            n.st = acp_pkg::RS_IDLE;
          end else begin
            n.idx  = q.idx + 4'h1;
            n.data = char_at(q, q.idx + 4'h1);
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      q <= '{st: acp_pkg::RS_IDLE, kind: acp_pkg::RPL_NO, default: '0};
    end else begin
      q <= n;
    end
  end

  assign tx_data  = q.data;
  assign tx_valid = (q.st == acp_pkg::RS_SEND);
  assign busy     = (q.st != acp_pkg::RS_IDLE);

endmodule : acp_reply

// File: rtl/acp_parser.sv
// addressed ascii command parser with config download sequencer
// Notes on behaviour
// - keep digits, capitals, comma, CR; extra symbols and space only inside names.
// - numbers come without point; the fixed-point format is applied downstream.
// - leading zeros in a number change nothing.
// - message is two capitals, address, comma, fields, CR, no trailing comma.
// - address 0 to 99; address 0 is obeyed by every unit.
// - own address zero means every message is ignored.
// - CR ends and triggers a message; linefeeds are ignored.
// - replies end in CR alone, never a linefeed.
// - good write answers Y then CR, failed command answers N then CR.
// - target setting accepted only within the program's lower and upper limits.
// - target and program writes are volatile; reset restores stored values.
// - parameter write takes page, item, value; out-of-range value is refused.
// - program name is exactly four characters, space allowed.
// - program change by number within configured minimum and maximum.
// - read answers value, comma, point code, CR; four digits with zeros.
// - point code is the number of digits after the displayed point.
// - page zero monitor items are readable over this serial path.
// - armed unit waits for save, three seconds, steps blocks 0 to 511, adopts.
// - failed transfer shows an error instead of adopting the configuration.
// - baud setting 1 to 5 takes effect only after power-up.
// - wait the turnaround delay, 1 to 50 times 10 ms, before replying.
module acp_parser #(
  parameter int TURN_STEP_CYC = acp_pkg::TURN_STEP_CYC,
  parameter int LOAD_HOLD_CYC = acp_pkg::LOAD_HOLD_CYC
) (
  input  wire logic        CLK_SYS,
  input  wire logic        RESET_N,
  input  wire logic [7:0]  RX_DATA,
  input  wire logic        RX_VALID,
  output logic      [7:0]  TX_DATA,
  output logic             TX_VALID,
  input  wire logic        TX_READY,
  input  wire logic [6:0]  NET_ADDR,
  input  wire logic [2:0]  BAUD_SETTING,
  output logic      [2:0]  BAUD_SEL,
  input  wire logic [5:0]  TURNAROUND,
  input  wire logic [13:0] STORED_TARGET,
  input  wire logic [2:0]  STORED_PROGRAM,
  input  wire logic [13:0] TARGET_LO,
  input  wire logic [13:0] TARGET_HI,
  input  wire logic [2:0]  PROG_MIN,
  input  wire logic [2:0]  PROG_MAX,
  output logic      [13:0] TARGET,
  output logic      [2:0]  PROGRAM,
  output logic             PARAM_REQ,
  output logic             PARAM_WRITE,
  output logic      [3:0]  PARAM_PAGE,
  output logic      [3:0]  PARAM_ITEM,
  output logic      [13:0] PARAM_WDATA,
  input  wire logic        PARAM_ACK,
  input  wire logic        PARAM_OK,
  input  wire logic [13:0] PARAM_RDATA,
  input  wire logic [2:0]  PARAM_DP,
  output logic             NAME_WR,
  output logic      [2:0]  NAME_PROG,
  output logic      [31:0] NAME_TEXT,
  input  wire logic        LOAD_ARM,
  input  wire logic        SAVE_SEEN,
  input  wire logic        BLOCK_STROBE,
  input  wire logic        BLOCK_ERR,
  output logic      [8:0]  BLOCK_COUNT,
  output logic             CFG_ADOPT,
  output logic             CFG_FAIL
);

  typedef struct packed {
    acp_pkg::acp_state_t st;
    logic                loaded;
    logic [15:0]         cmd;
    logic [6:0]          addr;
    logic                addr_ok;
    logic [13:0]         acc;
    logic                ndig;
    logic [1:0]          fidx;
    logic [2:0][13:0]    fld;
    logic [31:0]         name;
    logic [2:0]          nlen;
    logic                err;
    logic [13:0]         target;
    logic [2:0]          prog;
    logic [2:0]          baud;
    logic                name_wr;
    logic                param_req;
    logic                param_wr;
    logic                rpl_start;
    acp_pkg::acp_reply_t rpl_kind;
    logic [13:0]         rpl_val;
    logic [2:0]          rpl_dp;
    acp_pkg::acp_cfg_t   cfg;
    logic [29:0]         hold;
    logic [8:0]          blk;
    logic                cfg_bad;
    logic                cfg_adopt;
    logic                cfg_fail;
  } acp_ctl_t;

  acp_ctl_t q, n;
  logic     rpl_busy;

  function automatic logic is_digit(input logic [7:0] c);
    return (c >= acp_pkg::CHR_0) && (c <= acp_pkg::CHR_9);
  endfunction : is_digit

  function automatic logic is_upper(input logic [7:0] c);
    return (c >= acp_pkg::CHR_A) && (c <= acp_pkg::CHR_Z);
  endfunction : is_upper

  // decimal shift-in; the digit string is taken as a plain integer
  function automatic logic [14:0] push_digit(input logic [13:0] acc, input logic [7:0] c);
    logic [17:0] v;
    v = 18'(acc) * 18'd10 + 18'(c - acp_pkg::CHR_0);
    return {v > 18'(acp_pkg::VALUE_MAX), v[13:0]};
  endfunction : push_digit

  logic        is_dig;
  logic        is_up;
  logic        is_com;
  logic        is_cr;
  logic        is_sym;
  logic        addressed;
  logic        bcast;
  logic        ok;
  logic        wait_store;
  logic [14:0] pushed;

  always_comb begin
    n            = q;
    n.name_wr    = 1'b0;
    n.rpl_start  = 1'b0;
    n.cfg_adopt  = 1'b0;
    ok           = 1'b0;
    wait_store   = 1'b0;
    is_dig       = is_digit(RX_DATA);
    is_up        = is_upper(RX_DATA);
    is_com       = (RX_DATA == acp_pkg::CHR_COMMA);
    is_cr        = (RX_DATA == acp_pkg::CHR_CR);
    is_sym       = (RX_DATA == acp_pkg::CHR_SPACE) || (RX_DATA == acp_pkg::CHR_BANG) ||
                   (RX_DATA == acp_pkg::CHR_QUERY) || (RX_DATA == acp_pkg::CHR_EQUAL);
    pushed       = push_digit(q.acc, RX_DATA);
    bcast        = (q.addr == acp_pkg::ADDR_BCAST);
    addressed    = q.addr_ok && (NET_ADDR != acp_pkg::ADDR_BCAST) &&
                   (bcast || (q.addr == NET_ADDR));

    // stored values come back once after reset; later writes never reach the store
    if (!q.loaded) begin
      n.loaded = 1'b1;
      n.target = STORED_TARGET;
      n.prog   = STORED_PROGRAM;
      if (BAUD_SETTING >= acp_pkg::BAUD_MIN && BAUD_SETTING <= acp_pkg::BAUD_MAX)
        n.baud = BAUD_SETTING;
    end

    // linefeeds and any other character fall through without effect
    if (RX_VALID && (q.st != acp_pkg::ST_EXEC) && (q.st != acp_pkg::ST_WAIT)) begin
      unique case (q.st)
        acp_pkg::ST_IDLE: begin
          if (is_up) begin
            n.st      = acp_pkg::ST_CMD2;
            n.cmd     = {RX_DATA, 8'h00};
            n.addr_ok = 1'b0;
            n.err     = 1'b0;
            n.acc     = 14'h0;
            n.ndig    = 1'b0;
            n.fidx    = 2'h0;
            n.nlen    = 3'h0;
          end
        end
        acp_pkg::ST_CMD2: begin
          if (is_up) begin
            n.st     = acp_pkg::ST_ADDR;
            n.cmd    = {q.cmd[15:8], RX_DATA};
          end else if (is_cr) begin
            n.st = acp_pkg::ST_IDLE;
          end else if (is_dig || is_com) begin
            n.st = acp_pkg::ST_SKIP;
          end
        end
        acp_pkg::ST_ADDR: begin
          if (is_dig) begin
            n.acc  = pushed[13:0];
            n.ndig = 1'b1;
            if (pushed[14])
              n.st = acp_pkg::ST_SKIP;
          end else if (is_com) begin
            if (!q.ndig || q.acc > acp_pkg::ADDR_MAX) begin
              n.st = acp_pkg::ST_SKIP;
            end else begin
              n.st      = acp_pkg::ST_FIELD;
              n.addr    = q.acc[6:0];
              n.addr_ok = 1'b1;
              n.acc     = 14'h0;
              n.ndig    = 1'b0;
            end
          end else if (is_cr) begin
            n.st = acp_pkg::ST_IDLE;
          end else if (is_up) begin
            n.st = acp_pkg::ST_SKIP;
          end
        end
        acp_pkg::ST_FIELD: begin
          if (is_dig) begin
            n.acc  = pushed[13:0];
            n.ndig = 1'b1;
            if (pushed[14])
              n.st = acp_pkg::ST_SKIP;
          end else if (is_com) begin
            // an empty field is a stray or trailing comma
            if (!q.ndig || q.fidx == 2'h2) begin
              n.st = acp_pkg::ST_SKIP;
            end else begin
              n.fld[q.fidx] = q.acc;
              n.fidx        = q.fidx + 2'h1;
              n.acc         = 14'h0;
              n.ndig        = 1'b0;
              if (q.cmd == acp_pkg::CMD_LABEL_PROGRAM)
                n.st = acp_pkg::ST_NAME;
            end
          end else if (is_cr) begin
            n.fld[q.fidx] = q.acc;
            n.err         = !q.ndig;
            n.st          = acp_pkg::ST_EXEC;
          end else if (is_up) begin
            n.st = acp_pkg::ST_SKIP;
          end
        end
        acp_pkg::ST_NAME: begin
          if (is_dig || is_up || is_sym) begin
            if (q.nlen == acp_pkg::NAME_LEN) begin
              n.err = 1'b1;
            end else begin
              n.name = {q.name[23:0], RX_DATA};
              n.nlen = q.nlen + 3'h1;
            end
          end else if (is_com) begin
            n.st = acp_pkg::ST_SKIP;
          end else if (is_cr) begin
            n.err = q.err || (q.nlen != acp_pkg::NAME_LEN);
            n.st  = acp_pkg::ST_EXEC;
          end
        end
        acp_pkg::ST_SKIP: begin
          if (is_cr) begin
            n.err = 1'b1;
            n.st  = acp_pkg::ST_EXEC;
          end
        end
        default: ;
      endcase
    end

    if (q.st == acp_pkg::ST_EXEC && !rpl_busy) begin
      n.st = acp_pkg::ST_IDLE;
      if (addressed && !q.err) begin
        case (q.cmd)
          acp_pkg::CMD_SET_TARGET: begin
            if (q.fidx == 2'h0 && q.fld[0] >= TARGET_LO && q.fld[0] <= TARGET_HI) begin
              ok       = 1'b1;
              n.target = q.fld[0];
            end
          end
          acp_pkg::CMD_SELECT_PROGRAM: begin
            if (q.fidx == 2'h0 && q.fld[0] >= 14'(PROG_MIN) && q.fld[0] <= 14'(PROG_MAX)) begin
              ok     = 1'b1;
              n.prog = q.fld[0][2:0];
            end
          end
          acp_pkg::CMD_LABEL_PROGRAM: begin
            if (q.fidx == 2'h1 && q.fld[0] >= acp_pkg::PROG_FIRST &&
                q.fld[0] <= acp_pkg::PROG_LAST) begin
              ok        = 1'b1;
              n.name_wr = 1'b1;
            end
          end
          acp_pkg::CMD_WRITE_PARAM: begin
            // page zero holds monitor items, so writes there are refused
            if (q.fidx == 2'h2 && q.fld[0] != 14'h0 && q.fld[0] <= acp_pkg::SEL_MAX &&
                q.fld[1] <= acp_pkg::SEL_MAX) begin
              wait_store = 1'b1;
              n.param_wr = 1'b1;
            end
          end
          acp_pkg::CMD_READ_PARAM: begin
            if (q.fidx == 2'h1 && q.fld[0] <= acp_pkg::SEL_MAX &&
                q.fld[1] <= acp_pkg::SEL_MAX) begin
              wait_store = 1'b1;
              n.param_wr = 1'b0;
            end
          end
          default: ; // unknown command falls to the N answer
        endcase
      end
      if (wait_store) begin
        n.st        = acp_pkg::ST_WAIT;
        n.param_req = 1'b1;
      end else if (addressed && !bcast) begin
        // broadcasts are obeyed silently so units do not talk over each other
        n.rpl_start = 1'b1;
        n.rpl_kind  = ok ? acp_pkg::RPL_YES : acp_pkg::RPL_NO;
      end
    end

    if (q.st == acp_pkg::ST_WAIT && PARAM_ACK) begin
      n.param_req = 1'b0;
      n.st        = acp_pkg::ST_IDLE;
      n.rpl_start = !bcast;
      n.rpl_val   = PARAM_RDATA;
      n.rpl_dp    = PARAM_DP;
      if (!PARAM_OK)
        n.rpl_kind = acp_pkg::RPL_NO;
      else
        n.rpl_kind = q.param_wr ? acp_pkg::RPL_YES : acp_pkg::RPL_VALUE;
    end

    unique case (q.cfg)
      acp_pkg::CFG_IDLE: begin
        if (LOAD_ARM) begin
          n.cfg      = acp_pkg::CFG_ARMED;
          n.cfg_fail = 1'b0;
        end
      end
      acp_pkg::CFG_ARMED: begin
        if (!LOAD_ARM) begin
          n.cfg = acp_pkg::CFG_IDLE;
        end else if (SAVE_SEEN) begin
          n.cfg  = acp_pkg::CFG_HOLD;
          n.hold = 30'h0;
        end
      end
      acp_pkg::CFG_HOLD: begin
        n.hold = q.hold + 30'h1;
        if (q.hold == 30'(LOAD_HOLD_CYC - 1)) begin
          n.cfg     = acp_pkg::CFG_STEP;
          n.blk     = 9'h000;
          n.cfg_bad = 1'b0;
        end
      end
      acp_pkg::CFG_STEP: begin
        n.cfg_bad = q.cfg_bad || BLOCK_ERR;
        if (BLOCK_STROBE) begin
          if (q.blk == acp_pkg::BLOCK_LAST) begin
            n.cfg       = acp_pkg::CFG_IDLE;
            n.cfg_fail  = q.cfg_bad || BLOCK_ERR;
            n.cfg_adopt = !(q.cfg_bad || BLOCK_ERR);
          end else begin
            n.blk = q.blk + 9'h001;
          end
        end
      end
    endcase
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RESET_N) begin
      q <= '{st: acp_pkg::ST_IDLE, cfg: acp_pkg::CFG_IDLE, rpl_kind: acp_pkg::RPL_NO,
             baud: acp_pkg::BAUD_RESET, default: '0};
    end else begin
      q <= n;
    end
  end

  acp_reply #(
    .STEP_CYC (TURN_STEP_CYC)
  ) u_reply (
    .clk      (CLK_SYS),
    .rst_n    (RESET_N),
    .start    (q.rpl_start),
    .kind     (q.rpl_kind),
    .value    (q.rpl_val),
    .dp       (q.rpl_dp),
    .turn     (TURNAROUND),
    .tx_ready (TX_READY),
    .tx_data  (TX_DATA),
    .tx_valid (TX_VALID),
    .busy     (rpl_busy)
  );

  assign BAUD_SEL    = q.baud;
  assign TARGET      = q.target;
  assign PROGRAM     = q.prog;
  assign PARAM_REQ   = q.param_req;
  assign PARAM_WRITE = q.param_wr;
  assign PARAM_PAGE  = q.fld[0][3:0];
  assign PARAM_ITEM  = q.fld[1][3:0];
  assign PARAM_WDATA = q.fld[2];
  assign NAME_WR     = q.name_wr;
  assign NAME_PROG   = q.fld[0][2:0];
  assign NAME_TEXT   = q.name;
  assign BLOCK_COUNT = q.blk;
  assign CFG_ADOPT   = q.cfg_adopt;
  assign CFG_FAIL    = q.cfg_fail;

endmodule : acp_parser

// File: test/acp_parser_asserts.sv
// port-level assertions for the command parser
module acp_parser_asserts (
  input wire logic        CLK_SYS,
  input wire logic        RESET_N,
  input wire logic [7:0]  TX_DATA,
  input wire logic        TX_VALID,
  input wire logic        TX_READY,
  input wire logic [13:0] TARGET,
  input wire logic [13:0] TARGET_LO,
  input wire logic [13:0] TARGET_HI,
  input wire logic        PARAM_REQ,
  input wire logic        PARAM_ACK,
  input wire logic [3:0]  PARAM_PAGE,
  input wire logic [13:0] PARAM_WDATA,
  input wire logic        NAME_WR,
  input wire logic [2:0]  BAUD_SEL,
  input wire logic [8:0]  BLOCK_COUNT,
  input wire logic        CFG_ADOPT,
  input wire logic        CFG_FAIL
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RESET_N);
  a_tx_holds: assert property (TX_VALID && !TX_READY |=> TX_VALID && $stable(TX_DATA))
    else $error("reply character changed before taken");
  a_no_linefeed: assert property (TX_VALID |-> TX_DATA != 8'h0a)
    else $error("linefeed offered");
  a_yn_then_cr: assert property (TX_VALID && TX_READY && (TX_DATA == acp_pkg::CHR_Y ||
    TX_DATA == acp_pkg::CHR_N) |=> TX_VALID && TX_DATA == acp_pkg::CHR_CR)
    else $error("Y or N not followed by CR");
  a_req_holds: assert property (PARAM_REQ && !PARAM_ACK |=>
    PARAM_REQ && $stable(PARAM_PAGE) && $stable(PARAM_WDATA))
    else $error("store request changed before ack");
  a_name_pulse: assert property (NAME_WR |=> !NAME_WR)
    else $error("name strobe longer than one cycle");
  a_baud_range: assert property (BAUD_SEL >= acp_pkg::BAUD_MIN && BAUD_SEL <= acp_pkg::BAUD_MAX)
    else $error("baud code out of range");
  a_target_limits: assert property ($changed(TARGET) && $past(RESET_N) && $past(RESET_N, 2)
    |-> TARGET >= TARGET_LO && TARGET <= TARGET_HI)
    else $error("target set outside limits");
  a_block_step: assert property ($changed(BLOCK_COUNT) |->
    BLOCK_COUNT == $past(BLOCK_COUNT) + 9'h1 || BLOCK_COUNT == 9'h0)
    else $error("block counter jumped");
  a_adopt_pulse: assert property (CFG_ADOPT |=> !CFG_ADOPT)
    else $error("adopt longer than one cycle");
  a_fail_blocks: assert property (CFG_ADOPT |-> !CFG_FAIL)
    else $error("adopt while error shown");
  c_adopt: cover property (CFG_ADOPT);
  c_fail: cover property ($rose(CFG_FAIL));
  c_store: cover property (PARAM_REQ && PARAM_ACK);
endmodule : acp_parser_asserts

bind acp_parser acp_parser_asserts i_chk (.*);

// File: test/acp_store_model.sv
// parameter store behind the parser, latency varies with the page
module acp_store_model (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        req,
  input wire logic        wr,
  input wire logic [3:0]  page,
  input wire logic [3:0]  item,
  input wire logic [13:0] wdata,
  output logic            ack,
  output logic            ok,
  output logic     [13:0] rdata,
  output logic     [2:0]  dp
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [13:0] mem [256];
  logic [2:0]  wait_q;
  initial begin
    rdata = 14'h0;
    for (int i = 0; i < 256; i++) mem[i] = 14'(i * 37);
  end
  always @(posedge clk) begin
    ack <= 1'b0;
    rdata <= ~rdata; // idle bus inverts every cycle, so the last answer shows only every other cycle
    if (!rst_n) wait_q <= 3'h0;
    else if (req && !ack) begin
      if (wait_q < {1'b0, page[1:0]}) wait_q <= wait_q + 3'h1;
      else begin
        wait_q <= 3'h0;
        ack <= 1'b1;
        ok <= !wr || wdata <= 14'd1000;
        if (wr && wdata <= 14'd1000) mem[{page, item}] <= wdata;
        rdata <= mem[{page, item}];
        dp <= item[2:0];
      end
    end
  end
endmodule : acp_store_model

// File: test/tb.sv
// self-checking bench for the command parser
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  // bench nets carry the port names so the parser connects by name
  logic CLK_SYS, RESET_N, RX_VALID, TX_VALID, TX_READY, PARAM_REQ, PARAM_WRITE, PARAM_ACK;
  logic PARAM_OK, NAME_WR, LOAD_ARM, SAVE_SEEN, BLOCK_STROBE, BLOCK_ERR, CFG_ADOPT, CFG_FAIL;
  logic [7:0]  RX_DATA, TX_DATA;
  logic [6:0]  NET_ADDR;
  logic [2:0]  BAUD_SETTING, BAUD_SEL, STORED_PROGRAM, PROG_MIN, PROG_MAX, PROGRAM;
  logic [2:0]  NAME_PROG, PARAM_DP;
  logic [5:0]  TURNAROUND;
  logic [13:0] STORED_TARGET, TARGET_LO, TARGET_HI, TARGET, PARAM_WDATA, PARAM_RDATA;
  logic [3:0]  PARAM_PAGE, PARAM_ITEM;
  logic [8:0]  BLOCK_COUNT;
  logic [31:0] NAME_TEXT;
  int          bad_count, cmp_count, cyc, v, t, f;

  acp_parser #(.TURN_STEP_CYC(20), .LOAD_HOLD_CYC(50)) i_dut (.*);
  acp_store_model i_store (.clk(CLK_SYS), .rst_n(RESET_N), .req(PARAM_REQ),
    .wr(PARAM_WRITE), .page(PARAM_PAGE), .item(PARAM_ITEM), .wdata(PARAM_WDATA),
    .ack(PARAM_ACK), .ok(PARAM_OK), .rdata(PARAM_RDATA), .dp(PARAM_DP));

  initial begin
    CLK_SYS = 0;
    forever #2.5 CLK_SYS = ~CLK_SYS;
  end
  always @(posedge CLK_SYS) begin
    cyc++;
    if (cyc == 60000) begin
      bad_count++;
      complete_run;
    end
  end

  task automatic tick;
    @(posedge CLK_SYS);
    #1;
  endtask : tick
  task automatic check(input logic [79:0] seen, input logic [79:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  function automatic logic [79:0] pk(string s);
    pk = '0;
    foreach (s[i]) pk = {pk[71:0], s[i]};
  endfunction : pk
  // sends a message and its CR, then gathers the reply under random stalls
  task automatic talk(string s, string e);
    logic [79:0] r;
    int n;
    r = '0;
    f = -1;
    foreach (s[i]) begin
      RX_DATA = s[i];
      RX_VALID = 1;
      tick;
    end
    RX_DATA = 8'h0d;
    tick;
    RX_VALID = 0;
    for (n = 0; n < 400 && r[7:0] !== 8'h0d; n++) begin
      TX_READY = 1'($urandom_range(0, 1));
      if (TX_VALID === 1'b1 && f < 0) f = n;
      if (TX_VALID === 1'b1 && TX_READY) r = {r[71:0], TX_DATA};
      tick;
    end
    TX_READY = 0;
    check(r, pk(e));
  endtask : talk
  task automatic cfg(input logic err);
    logic a;
    a = 0;
    LOAD_ARM = 1;
    tick;
    SAVE_SEEN = 1;
    tick;
    SAVE_SEEN = 0;
    LOAD_ARM = 0;
    repeat (60) tick;
    for (int i = 0; i < 512; i++) begin
      if (i == 300) check(BLOCK_COUNT, 300);
      BLOCK_STROBE = 1;
      BLOCK_ERR = err && i == 100;
      tick;
      a = a | CFG_ADOPT;
      BLOCK_STROBE = 0;
      BLOCK_ERR = 0;
      tick;
    end
    repeat (4) begin
      a = a | CFG_ADOPT;
      tick;
    end
    check(a, !err);
    check(CFG_FAIL, err);
  endtask : cfg
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : complete_run

  initial begin
    {RESET_N, RX_VALID, TX_READY, LOAD_ARM, SAVE_SEEN, BLOCK_STROBE, BLOCK_ERR} = '0;
    {RX_DATA, NET_ADDR, BAUD_SETTING, TURNAROUND} = {8'h0, 7'h01, 3'h3, 6'h01};
    {STORED_TARGET, STORED_PROGRAM, TARGET_LO, TARGET_HI} = {14'd1234, 3'h2, 14'd100, 14'd2000};
    {PROG_MIN, PROG_MAX} = {3'h2, 3'h5};
    v = $urandom(32'hb0d31341);
    repeat (8) tick;
    RESET_N = 1;
    repeat (2) tick;
    check(TARGET, 1234);
    check(PROGRAM, 2);
    check(BAUD_SEL, 3);
    talk("SP1,500", "Y\015");
    check(f, 22);
    check(TARGET, 500);
    talk("SP1,0050", "N\015");
    talk("SpP1,0\n150", "Y\015");
    check(TARGET, 150);
    talk("SP1,,5", "N\015");
    talk("QQ1,5", "N\015");
    talk("SP2,700", "");
    talk("SP0,700", "");
    check(TARGET, 700);
    talk("CP1,3", "Y\015");
    check(PROGRAM, 3);
    talk("CP1,1", "N\015");
    talk("SV1,7,1,2", "Y\015");
    talk("SV1,7,1,5000", "N\015");
    talk("RV1,7,1", "0002,0001\015");
    talk("RV1,0,2", "0074,0002\015");
    talk("NP1,3,F ?!", "Y\015");
    check(NAME_TEXT, pk("F ?!"));
    check(NAME_PROG, 3);
    talk("NP1,3,FAS", "N\015");
    $display("command tests done");
    t = 700;
    repeat (8) begin
      v = $urandom_range(0, 2500);
      if (v >= 100 && v <= 2000) t = v;
      talk($sformatf("SP1,%0d", v), (v >= 100 && v <= 2000) ? "Y\015" : "N\015");
      check(TARGET, t);
    end
    NET_ADDR = 0;
    talk("SP1,900", "");
    check(TARGET, t);
    NET_ADDR = 1;
    $display("random target tests done");
    cfg(0);
    cfg(1);
    cfg(0);
    $display("download tests done");
    STORED_TARGET = 14'd777;
    BAUD_SETTING = 3'h7;
    TURNAROUND = 6'h00;
    RESET_N = 0;
    tick;
    RESET_N = 1;
    repeat (2) tick;
    check(TARGET, 777);
    check(BAUD_SEL, 1);
    talk("SP1,600", "Y\015");
    check(f, 22);
    $display("reset tests done");
    complete_run;
  end
endmodule : tb
